/* File: inc/stc_pkg.sv */
// constants shared by the status and tick counter register bank
// assumes one 100 mhz clock and a byte-wide read port
package stc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_TICK_COUNTER   = 8'h00;
   localparam logic [7:0] ADDR_STATUS_SUMMARY = 8'h01;
   localparam logic [7:0] ADDR_SUPPLY_STATUS  = 8'h02;
   localparam logic [7:0] ADDR_MEM_THERMAL    = 8'h03;

   localparam logic [7:0] TICK_RESET          = 8'h00;
   localparam logic [7:0] SUPPLY_RESET        = 8'h00;
   localparam logic [7:0] ZERO_BYTE           = 8'h00;

   // ------------------------------------------------------------
   // summary bit positions
   // ------------------------------------------------------------
   localparam int SUM_DSP      = 7;
   localparam int SUM_LINK     = 5;
   localparam int SUM_MEMTHERM = 4;
   localparam int SUM_SUPPLY   = 3;
   localparam int SUM_TEST     = 2;
   localparam int SUM_RESET    = 1;
   localparam int SUM_INIT     = 0;

   // ------------------------------------------------------------
   // supply status bit positions (bit 4 is reserved)
   // ------------------------------------------------------------
   localparam int SUP_BUF_LOW  = 7;
   localparam int SUP_BUS_LOW  = 6;
   localparam int SUP_BUF_HIGH = 5;
   localparam int SUP_ANA_REG  = 3;
   localparam int SUP_DIG_REG  = 2;
   localparam int SUP_ROM_REG  = 1;
   localparam int SUP_CONT     = 0;

   // ------------------------------------------------------------
   // memory and thermal status bit positions
   // ------------------------------------------------------------
   localparam int MT_FACTORY   = 7;
   localparam int MT_USER_ROM  = 6;
   localparam int MT_USER_ARR  = 5;
   localparam int MT_WRITE_ACT = 4;
   localparam int MT_THERMAL   = 2;

   // ------------------------------------------------------------
   // protocol select codes
   // ------------------------------------------------------------
   localparam logic [2:0] PROTO_DSI3_A = 3'h0;
   localparam logic [2:0] PROTO_DSI3_B = 3'h3;
   localparam logic [2:0] PROTO_PSI5_A = 3'h1;
   localparam logic [2:0] PROTO_PSI5_B = 3'h5;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_TIME_US   = 100;
   localparam int PRESCALE_DIV   = 1000;
   localparam int OSC_PERIOD_NS  = TICK_TIME_US * 1000 / PRESCALE_DIV;
   localparam int OSC_DIV_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [9:0] PRESCALE_LAST = 10'(PRESCALE_DIV - 1);
   // recovery time counted in ticks; value not given, plain default
   localparam logic [15:0] RECOVERY_TICKS = 16'h0064;
   localparam logic [15:0] TIMER_ZERO     = 16'h0000;

   function automatic logic is_dsi3(input logic [2:0] ps);
      is_dsi3 = (ps == PROTO_DSI3_A) || (ps == PROTO_DSI3_B);
   endfunction : is_dsi3

   function automatic logic is_psi5(input logic [2:0] ps);
      is_psi5 = (ps == PROTO_PSI5_A) || (ps == PROTO_PSI5_B);
   endfunction : is_psi5

endpackage : stc_pkg

/* File: rtl/stc_tick_gen.sv */
// tick generator: primary oscillator model, 10-bit prescaler, 8-bit counter
// assumes clk is 100 mhz; osc_div_cycles clocks make one oscillator period
module stc_tick_gen #(
   parameter int OSC_DIV = stc_pkg::OSC_DIV_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   output logic            tick,
   output logic [7:0]      count
);
   localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);

   logic [15:0] osc_q;
   logic [9:0]  pre_q;
   logic        tick_q;
   logic [7:0]  count_q;
   wire         osc_edge = (osc_q == OSC_LAST);
   wire         pre_wrap = osc_edge && (pre_q == stc_pkg::PRESCALE_LAST);

   // ------------------------------------------------------------
   // dividers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_q   <= 16'h0000;
         pre_q   <= 10'h000;
         tick_q  <= 1'b0;
         count_q <= stc_pkg::TICK_RESET;
      end else begin
         osc_q  <= osc_edge ? 16'h0000 : osc_q + 16'h0001;
         pre_q  <= pre_wrap ? 10'h000 : (osc_edge ? pre_q + 10'h001 : pre_q);
         tick_q <= pre_wrap;
         if (pre_wrap) begin
            count_q <= count_q + 8'h01;
         end
      end
   end

   assign tick  = tick_q;
   assign count = count_q;

endmodule : stc_tick_gen

/* File: rtl/stc_status_regs.sv */
// status and tick counter register bank with supply recovery timer
// assumes all inputs are synchronous to clk; reads arrive on a byte port
// Contract
// - 10-bit prescaler divides oscillator by 1000; 8-bit counter steps every 100 us, wraps.
// - tick counter reads at offset 0x00, resets to zero.
// - reads allowed only in DSI3 mode or PSI5 diagnostic mode.
// - summary bit 7 is OR of five signal-processing fault flags.
// - summary bit 5 follows the oscillator training fault.
// - summary bit 4 is OR of memory, write-active and thermal bits.
// - summary bit 3 is OR of the seven supply flags.
// - one recovery timer reloads while a supply fault persists, else counts down per tick.
// - DSI3 with hold-off 0: silent until timer expires, then one error-code response.
// - DSI3 with hold-off 0: read or reporting frame clears supply flags only at zero; the two-read clear works at any timer value.
// - PSI5 or hold-off 1: no frames while timer nonzero; flags clear at zero.
// - reset-occurred bit set by reset, cleared by summary read or reporting frame.
// - init bit set by reset or config [7:4] change, cleared when data valid.
// - two consecutive supply reads with no fault present clear the supply register.
// - supply bit 7 set by buffer rail undervoltage.
// - supply bit 6 set by bus input undervoltage.
// - memory and thermal faults cleared by their register read or reporting frame.
// - supply bit 0 set by perimeter continuity break.
module stc_status_regs #(
   parameter logic [15:0] RECOVERY_TICKS = stc_pkg::RECOVERY_TICKS,
   parameter int          OSC_DIV        = stc_pkg::OSC_DIV_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   // read port
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   output logic            reg_rd_ack,
   output logic [7:0]      reg_rd_data,
   // mode
   input  wire logic [2:0] protocol_select,
   input  wire logic       psi5_diag_mode,
   input  wire logic       power_fault_hold_off_select,
   input  wire logic [3:0] channel_user_config,
   input  wire logic       data_valid,
   input  wire logic       test_active,
   // signal processing and link faults
   input  wire logic       pressure_over_range,
   input  wire logic       pressure_under_range,
   input  wire logic       selftest_incomplete,
   input  wire logic       common_mode_fault,
   input  wire logic       selftest_fault,
   input  wire logic       oscillator_training_fault,
   // memory and thermal events
   input  wire logic       factory_rom_fault,
   input  wire logic       user_rom_fault,
   input  wire logic       user_array_fault,
   input  wire logic       user_rom_write_active,
   input  wire logic       thermal_fault,
   // supply monitors, high while the condition exists
   input  wire logic       buffer_rail_low,
   input  wire logic       bus_input_low,
   input  wire logic       buffer_rail_high,
   input  wire logic       analog_regulator_fault,
   input  wire logic       digital_regulator_fault,
   input  wire logic       rom_regulator_fault,
   input  wire logic       perimeter_continuity_fault,
   // frame slot from the link engine
   input  wire logic       frame_req,
   output logic            frame_go,
   output logic            frame_error_code,
   output logic [7:0]      frame_status,
   output logic [7:0]      tick_counter
);

   // ------------------------------------------------------------
   // tick source
   // ------------------------------------------------------------
   logic       tick;
   logic [7:0] count;

   stc_tick_gen #(
      .OSC_DIV (OSC_DIV)
   ) u_tick (
      .clk     (clk),
      .rst     (rst),
      .tick    (tick),
      .count   (count)
   );

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]  sup_q;
   logic [7:0]  sup_d;
   logic [15:0] timer_q;
   logic [15:0] timer_d;
   logic [7:0]  mt_q;
   logic [7:0]  mt_d;
   logic        rstocc_q;
   logic        init_q;
   logic [3:0]  cfg_q;
   logic        owed_q;
   logic        last_sup_rd_q;
   logic        rd_ack_q;
   logic [7:0]  rd_data_q;
   logic        go_q;
   logic        errc_q;
   logic [7:0]  fstat_q;
   logic [7:0]  tick_q;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire dsi3      = stc_pkg::is_dsi3(protocol_select);
   wire psi5      = stc_pkg::is_psi5(protocol_select);
   wire hold0     = dsi3 && !power_fault_hold_off_select;
   wire auto_clr  = psi5 || power_fault_hold_off_select;
   wire timer_idle = (timer_q == stc_pkg::TIMER_ZERO);

   wire readable  = dsi3 || psi5_diag_mode;
   wire rd_ok     = reg_rd && readable;
   wire rd_sum    = rd_ok && (reg_addr == stc_pkg::ADDR_STATUS_SUMMARY);
   wire rd_sup    = rd_ok && (reg_addr == stc_pkg::ADDR_SUPPLY_STATUS);
   wire rd_mt     = rd_ok && (reg_addr == stc_pkg::ADDR_MEM_THERMAL);

   wire [7:0] sup_mon = {buffer_rail_low, bus_input_low, buffer_rail_high, 1'b0,
                         analog_regulator_fault, digital_regulator_fault,
                         rom_regulator_fault, perimeter_continuity_fault};
   wire       mon_any = |sup_mon;

   wire [7:0] mt_set = {factory_rom_fault, user_rom_fault, user_array_fault, 1'b0,
                        1'b0, thermal_fault, 2'b00};
   // write-active is a live level, not a sticky flag
   wire [7:0] mt_view = mt_q | ({7'h00, user_rom_write_active} << stc_pkg::MT_WRITE_ACT);

   // ------------------------------------------------------------
   // summary
   // ------------------------------------------------------------
   logic [7:0] sum_w;
   always_comb begin
      sum_w = stc_pkg::ZERO_BYTE;
      sum_w[stc_pkg::SUM_DSP] = pressure_over_range | pressure_under_range |
                                selftest_incomplete | common_mode_fault | selftest_fault;
      sum_w[stc_pkg::SUM_LINK] = oscillator_training_fault;
      sum_w[stc_pkg::SUM_MEMTHERM] = |mt_view;
      sum_w[stc_pkg::SUM_SUPPLY] = |sup_q;
      sum_w[stc_pkg::SUM_TEST] = test_active;
      sum_w[stc_pkg::SUM_RESET] = rstocc_q;
      sum_w[stc_pkg::SUM_INIT] = init_q;
   end

   // ------------------------------------------------------------
   // frame gating
   // ------------------------------------------------------------
   // silent while timer runs, suppress while nonzero
   // auto-clear modes also wait the cycle the flags take to clear
   // so the first resumed frame never carries a stale supply fault
   wire sup_wait   = auto_clr && sum_w[stc_pkg::SUM_SUPPLY];
   wire frame_ok   = frame_req && timer_idle && !sup_wait;
   wire send_err   = frame_ok && hold0 && owed_q;
   wire rep_sup    = frame_ok && sum_w[stc_pkg::SUM_SUPPLY];
   wire rep_mt     = frame_ok && sum_w[stc_pkg::SUM_MEMTHERM];
   wire rep_rst    = frame_ok && rstocc_q;

   // ------------------------------------------------------------
   // supply flags and timer
   // ------------------------------------------------------------
   // clear on read or frame only at zero
   wire clr_dsi    = hold0 && timer_idle && (rd_sup || rep_sup);
   wire clr_auto   = auto_clr && timer_idle;
   // second consecutive read with no fault present
   wire clr_twice  = rd_sup && last_sup_rd_q && !mon_any;
   wire sup_clr    = clr_dsi || clr_auto || clr_twice;

   always_comb begin
      // set wins over clear
      sup_d = (sup_clr ? stc_pkg::SUPPLY_RESET : sup_q) | sup_mon;
      // reload while fault present, else count down per tick
      if (mon_any) begin
         timer_d = RECOVERY_TICKS;
      end else if (tick && !timer_idle) begin
         timer_d = timer_q - 16'h0001;
      end else begin
         timer_d = timer_q;
      end
      // clear on read or reporting frame
      mt_d = ((rd_mt || rep_mt) ? stc_pkg::ZERO_BYTE : mt_q) | mt_set;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sup_q   <= stc_pkg::SUPPLY_RESET;
         timer_q <= stc_pkg::TIMER_ZERO;
         mt_q    <= stc_pkg::ZERO_BYTE;
      end else begin
         sup_q   <= sup_d;
         timer_q <= timer_d;
         mt_q    <= mt_d;
      end
   end

   // ------------------------------------------------------------
   // reset, init and owed error code
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rstocc_q      <= 1'b1;
         init_q        <= 1'b1;
         cfg_q         <= 4'h0;
         owed_q        <= 1'b0;
         last_sup_rd_q <= 1'b0;
      end else begin
         rstocc_q      <= rstocc_q && !(rd_sum || rep_rst);
         // config change wins over data valid
         init_q        <= (channel_user_config != cfg_q) || (init_q && !data_valid);
         cfg_q         <= channel_user_config;
         owed_q        <= mon_any || (owed_q && !send_err);
         // a fresh supply fault restarts the two-read count
         if (mon_any) begin
            last_sup_rd_q <= 1'b0;
         end else if (rd_ok) begin
            last_sup_rd_q <= rd_sup;
         end
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   logic [7:0] rd_mux;
   always_comb begin
      case (reg_addr)
         stc_pkg::ADDR_TICK_COUNTER:   rd_mux = count;
         stc_pkg::ADDR_STATUS_SUMMARY: rd_mux = sum_w;
         stc_pkg::ADDR_SUPPLY_STATUS:  rd_mux = sup_q;
         stc_pkg::ADDR_MEM_THERMAL:    rd_mux = mt_view;
         default:                      rd_mux = stc_pkg::ZERO_BYTE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_ack_q  <= 1'b0;
         rd_data_q <= stc_pkg::ZERO_BYTE;
         go_q      <= 1'b0;
         errc_q    <= 1'b0;
         fstat_q   <= stc_pkg::ZERO_BYTE;
         tick_q    <= stc_pkg::TICK_RESET;
      end else begin
         rd_ack_q  <= rd_ok;
         rd_data_q <= rd_ok ? rd_mux : rd_data_q;
         go_q      <= frame_ok;
         errc_q    <= send_err;
         fstat_q   <= frame_ok ? sum_w : fstat_q;
         tick_q    <= count;
      end
   end

   assign reg_rd_ack       = rd_ack_q;
   assign reg_rd_data      = rd_data_q;
   assign frame_go         = go_q;
   assign frame_error_code = errc_q;
   assign frame_status     = fstat_q;
   assign tick_counter     = tick_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_count_step;
      @(posedge clk) disable iff (rst)
      tick |-> (count == $past(count) + 8'h01);
   endproperty
   a_count_step: assert property (p_count_step) else $error("tick count did not step");

   property p_refused;
      @(posedge clk) disable iff (rst)
      (reg_rd && !dsi3 && !psi5_diag_mode) |=> !reg_rd_ack;
   endproperty
   a_refused: assert property (p_refused) else $error("read acked outside read modes");

   property p_dsp_or;
      @(posedge clk) disable iff (rst)
      (rd_sum && pressure_over_range) |=> reg_rd_data[stc_pkg::SUM_DSP];
   endproperty
   a_dsp_or: assert property (p_dsp_or) else $error("summary bit 7 missed fault");

   property p_supply_or;
      @(posedge clk) disable iff (rst)
      (rd_sum && (sup_q != stc_pkg::ZERO_BYTE)) |=> reg_rd_data[stc_pkg::SUM_SUPPLY];
   endproperty
   a_supply_or: assert property (p_supply_or) else $error("summary bit 3 missed supply");

   property p_reload;
      @(posedge clk) disable iff (rst)
      buffer_rail_low |=> (timer_q == RECOVERY_TICKS) && sup_q[stc_pkg::SUP_BUF_LOW];
   endproperty
   a_reload: assert property (p_reload) else $error("timer not reloaded");

   property p_silent;
      @(posedge clk) disable iff (rst)
      (frame_req && !timer_idle) |=> !frame_go;
   endproperty
   a_silent: assert property (p_silent) else $error("frame sent while timer runs");

   property p_hold_flags;
      @(posedge clk) disable iff (rst)
      (hold0 && !timer_idle && !clr_twice) |=> ((sup_q & $past(sup_q)) == $past(sup_q));
   endproperty
   a_hold_flags: assert property (p_hold_flags) else $error("supply flag lost early");

   property p_auto_clear;
      @(posedge clk) disable iff (rst)
      (psi5 && timer_idle && !mon_any) |=> (sup_q == stc_pkg::ZERO_BYTE);
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("flags not cleared at zero");

   property p_reset_flag;
      @(posedge clk)
      rst |=> rstocc_q && init_q;
   endproperty
   a_reset_flag: assert property (p_reset_flag) else $error("reset flags not set");

   property p_cfg_init;
      @(posedge clk) disable iff (rst)
      (channel_user_config != cfg_q) |=> init_q;
   endproperty
   a_cfg_init: assert property (p_cfg_init) else $error("init not set on change");

endmodule : stc_status_regs

/* File: sim/stc_link_model.sv */
// link engine model: asks for frames and records what the block sends back
// assumes the block answers frame_req with a frame_go pulse, or drops it
module stc_link_model (
   input  wire logic       clk,
   input  wire logic       send,
   input  wire logic       clr,
   output logic            frame_req,
   input  wire logic       frame_go,
   input  wire logic       frame_error_code,
   input  wire logic [7:0] frame_status,
   output int              n_frames,
   output int              n_errs,
   output logic            first_err,
   output logic [7:0]      first_stat
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] gap_q;
   // ----------------------------------------
   // frame slots
   // ----------------------------------------
   // one request every four cycles, as a polling master would;
   // changed just after the rising edge so the block samples a settled level
   always @(posedge clk) begin
      if (clr) begin
         gap_q <= 2'h0;
         frame_req <= 1'b0;
      end else begin
         gap_q <= gap_q + 2'h1;
         frame_req <= send && (gap_q == 2'h0);
      end
   end
   // ----------------------------------------
   // frame log
   // ----------------------------------------
   always @(posedge clk) begin
      if (clr) begin
         n_frames <= 0;
         n_errs <= 0;
      end else if (frame_go === 1'b1) begin
         if (n_frames == 0) begin
            first_err <= frame_error_code;
            first_stat <= frame_status;
         end
         n_frames <= n_frames + 1;
         n_errs <= n_errs + int'(frame_error_code);
      end
   end
endmodule : stc_link_model

/* File: sim/tb_top.sv */
// self-checking bench for the status and tick counter register bank
// assumes short counts: one tick per 1000 clocks, recovery of 3 ticks
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, reg_rd, reg_rd_ack, psi5_diag_mode, hold_off, data_valid;
   logic frame_req, frame_go, frame_error_code, link_send, link_clr, first_err;
   logic [7:0] reg_addr, reg_rd_data, frame_status, tick_counter, first_stat;
   logic [2:0] protocol_select;
   logic [3:0] cfg;
   logic [11:0] flt;
   logic [6:0] sup;
   int num_errors, checked, n_frames, n_errs, m;
   logic [7:0] sum_e [12] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h20,
                              8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h04};
   logic [7:0] mt_e [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h80, 8'h40, 8'h20, 8'h00, 8'h04, 8'h00};
   logic [7:0] sup_e [7] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h02, 8'h01};

   stc_status_regs #(.RECOVERY_TICKS(16'h0003), .OSC_DIV(1)) i_dut (
      .clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_rd_ack(reg_rd_ack), .reg_rd_data(reg_rd_data),
      .protocol_select(protocol_select), .psi5_diag_mode(psi5_diag_mode),
      .power_fault_hold_off_select(hold_off), .channel_user_config(cfg),
      .data_valid(data_valid), .test_active(flt[11]),
      .pressure_over_range(flt[0]), .pressure_under_range(flt[1]),
      .selftest_incomplete(flt[2]), .common_mode_fault(flt[3]),
      .selftest_fault(flt[4]), .oscillator_training_fault(flt[5]),
      .factory_rom_fault(flt[6]), .user_rom_fault(flt[7]), .user_array_fault(flt[8]),
      .user_rom_write_active(flt[9]), .thermal_fault(flt[10]),
      .buffer_rail_low(sup[0]), .bus_input_low(sup[1]), .buffer_rail_high(sup[2]),
      .analog_regulator_fault(sup[3]), .digital_regulator_fault(sup[4]),
      .rom_regulator_fault(sup[5]), .perimeter_continuity_fault(sup[6]),
      .frame_req(frame_req), .frame_go(frame_go), .frame_error_code(frame_error_code),
      .frame_status(frame_status), .tick_counter(tick_counter));

   stc_link_model i_link (
      .clk(clk), .send(link_send), .clr(link_clr), .frame_req(frame_req),
      .frame_go(frame_go), .frame_error_code(frame_error_code),
      .frame_status(frame_status), .n_frames(n_frames), .n_errs(n_errs),
      .first_err(first_err), .first_stat(first_stat));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic give_verdict();
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp

   // the answer is due in the cycle right after the taking edge
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic ok);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      reg_rd = 1'b0;
      cmp("rd_ack", {7'h00, ok}, {7'h00, reg_rd_ack});
      if (ok) cmp("rd_data", e, reg_rd_data);
   endtask : rd

   task automatic pulse_valid();
      data_valid = 1'b1;
      @(negedge clk);
      data_valid = 1'b0;
      repeat (2) @(negedge clk);
   endtask : pulse_valid

   // ----------------------------------------
   // clock, watchdog
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // the whole run needs some 34000 cycles
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      give_verdict();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      rst = 1'b1; reg_rd = 1'b0; reg_addr = 8'h00; protocol_select = 3'h0;
      psi5_diag_mode = 1'b0; hold_off = 1'b0; data_valid = 1'b0; cfg = 4'h0;
      flt = 12'h000; sup = 7'h00; link_send = 1'b0; link_clr = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      link_clr = 1'b0;
      rd(8'h00, 8'h00, 1'b1);
      rd(8'h01, 8'h03, 1'b1);
      rd(8'h01, 8'h01, 1'b1);
      rd(8'h05, 8'h00, 1'b1);
      rd(8'h02, 8'h00, 1'b1);
      pulse_valid();
      rd(8'h01, 8'h00, 1'b1);
      cfg = 4'h5;
      repeat (2) @(negedge clk);
      rd(8'h01, 8'h01, 1'b1);
      pulse_valid();
      protocol_select = 3'h1;
      rd(8'h01, 8'h00, 1'b0);
      psi5_diag_mode = 1'b1;
      rd(8'h01, 8'h00, 1'b1);
      protocol_select = 3'h0;
      psi5_diag_mode = 1'b0;
      // tick period measured edge to edge
      for (int k = 0; k < 1100 && tick_counter === 8'h00; k++) @(negedge clk);
      cmp("tick", 8'h01, tick_counter);
      repeat (999) @(negedge clk);
      cmp("tick", 8'h01, tick_counter);
      @(negedge clk);
      cmp("tick", 8'h02, tick_counter);
      rd(8'h00, 8'h02, 1'b1);
      // one fault source at a time into the summary
      for (int i = 0; i < 12; i++) begin
         flt = 12'h001 << i;
         repeat (2) @(negedge clk);
         rd(8'h01, sum_e[i], 1'b1);
         flt = 12'h000;
         repeat (2) @(negedge clk);
         rd(8'h03, mt_e[i], 1'b1);
         rd(8'h03, 8'h00, 1'b1);
         rd(8'h01, 8'h00, 1'b1);
      end
      // supply faults under DSI3 hold-off 0, DSI3 hold-off 1 and PSI5
      for (int i = 0; i < 7; i++) begin
         m = i % 3;
         protocol_select = (m == 0) ? 3'h0 : (m == 1) ? 3'h3 : 3'h5;
         hold_off = (m == 1);
         psi5_diag_mode = (m == 2);
         sup = 7'h01 << i;
         repeat (2) @(negedge clk);
         link_clr = 1'b1;
         link_send = 1'b1;
         @(negedge clk);
         link_clr = 1'b0;
         sup = 7'h00;
         rd(8'h02, sup_e[i], 1'b1);
         rd(8'h01, 8'h08, 1'b1);
         repeat (1500) @(negedge clk);
         cmp("frames_held", 8'h00, 8'(n_frames));
         repeat (3000) @(negedge clk);
         cmp("frames_sent", 8'h01, {7'h00, n_frames > 0});
         cmp("err_first", {7'h00, m == 0}, {7'h00, first_err});
         cmp("err_count", (m == 0) ? 8'h01 : 8'h00, 8'(n_errs));
         cmp("frame_stat", (m == 0) ? 8'h08 : 8'h00, first_stat);
         link_send = 1'b0;
         rd(8'h02, 8'h00, 1'b1);
      end
      protocol_select = 3'h0;
      hold_off = 1'b0;
      psi5_diag_mode = 1'b0;
      // mid-run reset: the first frame reports both reset flags and clears one
      rst = 1'b1;
      link_clr = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      link_clr = 1'b0;
      link_send = 1'b1;
      repeat (12) @(negedge clk);
      link_send = 1'b0;
      cmp("frame_stat", 8'h03, first_stat);
      cmp("err_count", 8'h00, 8'(n_errs));
      rd(8'h01, 8'h01, 1'b1);
      // two reads in a row empty the supply register once the fault is gone
      sup = 7'h40;
      repeat (2) @(negedge clk);
      sup = 7'h00;
      rd(8'h02, 8'h01, 1'b1);
      rd(8'h02, 8'h01, 1'b1);
      rd(8'h02, 8'h00, 1'b1);
      give_verdict();
   end
endmodule : tb_top
